// File: inc/ppf_params.svh
// Constants for the port pin function configuration block.
// Assumes inclusion by the package and the design file only.
`ifndef PPF_PARAMS_SVH
`define PPF_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices as printed; byte address is four times these
// ----------------------------------------------------------------
`define PPF_IDX_P7_DRIVE 8'h1F
`define PPF_IDX_P8_CFG_HI 8'h20
`define PPF_IDX_P8_CFG_LO 8'h21
`define PPF_ADDR_W 8
`define PPF_BYTE_LSB 2

// ----------------------------------------------------------------
// Field layout, reset values and encodings
// ----------------------------------------------------------------
`define PPF_REG_W 8
`define PPF_PINS 8
`define PPF_HALF_PINS 4
`define PPF_FIELD_W 2
`define PPF_RESET_VAL 8'h00
`define PPF_FN_INPUT 2'h0
`define PPF_FN_EXTMEM 2'h1
`define PPF_FN_LCD 2'h2
`define PPF_FN_OUTPUT 2'h3
`define PPF_RESP_OKAY 2'h0
`define PPF_RESP_SLVERR 2'h2
`define PPF_DATA_W 32

`endif

// File: inc/ppf_pkg.sv
// Types for the port pin function configuration block.
// Assumes ppf_params.svh lies on the include path.
`include "ppf_params.svh"

package ppf_pkg;

  // ----------------------------------------------------------------
  // Configuration registers as seen by the pin logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`PPF_REG_W-1:0] p7_drive;
    logic [`PPF_REG_W-1:0] p8_cfg_hi;
    logic [`PPF_REG_W-1:0] p8_cfg_lo;
  } ppf_cfg_s;

  // ----------------------------------------------------------------
  // Whole state of the block, bus slave included
  // ----------------------------------------------------------------
  typedef struct packed {
    ppf_cfg_s cfg;
    logic aw_full;
    logic [`PPF_ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [`PPF_REG_W-1:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [`PPF_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } ppf_state_s;

  // Per-pin decoded function flags of port 8
  typedef struct packed {
    logic [`PPF_PINS-1:0] ext_mem_sel;
    logic [`PPF_PINS-1:0] lcd_segment_output_sel;
    logic [`PPF_PINS-1:0] out_en_n;
  } ppf_p8_fn_s;

endpackage : ppf_pkg

// File: logic/ppf_top.sv
// Port 7 drive mode and port 8 pin function configuration,
// reached over an AXI4-Lite slave.
// Assumes one clock, synchronous inputs, a master that keeps the
// AXI4-Lite handshake rules.
// How it works
// R1: Field code 00 input, 01 external memory, 10 LCD segment, 11 output.
// R2: High port 8 register holds pins 7..4, pin 7 in bits 7-6.
// R3: Low port 8 register holds pins 3..0, pin 3 in bits 7-6.
// R4: Port 7 drive bit 0 is push-pull, 1 is low-side open-drain.
// R5: Registers reached only at their exact direct addresses, nothing else.
// R6: Pull-up forced off for push-pull output or alternate function.
// R7: All configuration bits clear on reset: inputs, push-pull drive.
`timescale 1ns/1ps
`include "ppf_params.svh"

module ppf_top #(
  parameter int ADDR_W = `PPF_ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`PPF_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`PPF_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`PPF_PINS-1:0] p7_pullup_en,
  input wire logic [`PPF_PINS-1:0] p7_active_fn,
  input wire logic [`PPF_PINS-1:0] p8_pullup_en,
  input wire logic [`PPF_PINS-1:0] p8_open_drain,
  output ppf_pkg::ppf_cfg_s cfg,
  output ppf_pkg::ppf_p8_fn_s p8_fn,
  output logic [`PPF_PINS-1:0] p7_open_drain,
  output logic [`PPF_PINS-1:0] p7_pullup_on,
  output logic [`PPF_PINS-1:0] p8_pullup_on
);
  import ppf_pkg::*;

  ppf_state_s st_reg;
  ppf_state_s st_next;
  logic [`PPF_FIELD_W-1:0] p8_field [`PPF_PINS];
  logic do_write;
  logic [ADDR_W-1:0] wr_addr;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Only an aligned word at four times a printed index hits; any
  // other form, aliases and byte offsets included, is refused.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
    logic [ADDR_W-1:0] want;
    // Index to byte address; bits above ADDR_W are dropped on purpose
    want = ADDR_W'(idx) << `PPF_BYTE_LSB;
    return a == want; // R5
  endfunction : addr_hit

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return addr_hit(a, `PPF_IDX_P7_DRIVE) ||
           addr_hit(a, `PPF_IDX_P8_CFG_HI) ||
           addr_hit(a, `PPF_IDX_P8_CFG_LO); // R5
  endfunction : addr_known

  // ----------------------------------------------------------------
  // Bus handshake and next-state logic
  // ----------------------------------------------------------------
  // One outstanding write and one read; address and data may come in
  // either order, the response waits for both.
  assign s_axi_awready = !st_reg.aw_full && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_full && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign wr_addr = st_reg.aw_addr;
  assign do_write = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;

  always_comb begin
    st_next = st_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata[`PPF_REG_W-1:0];
      st_next.w_lane0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = addr_known(wr_addr) ? `PPF_RESP_OKAY
                                          : `PPF_RESP_SLVERR; // R5
      if (st_reg.w_lane0) begin
        if (addr_hit(wr_addr, `PPF_IDX_P7_DRIVE)) begin
          st_next.cfg.p7_drive = st_reg.w_data; // R4
        end
        if (addr_hit(wr_addr, `PPF_IDX_P8_CFG_HI)) begin
          st_next.cfg.p8_cfg_hi = st_reg.w_data; // R2
        end
        if (addr_hit(wr_addr, `PPF_IDX_P8_CFG_LO)) begin
          st_next.cfg.p8_cfg_lo = st_reg.w_data; // R3
        end
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Read data is captured at address acceptance, answered next cycle
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = `PPF_RESP_OKAY;
      st_next.rdata = '0;
      if (addr_hit(s_axi_araddr, `PPF_IDX_P7_DRIVE)) begin
        st_next.rdata[`PPF_REG_W-1:0] = st_reg.cfg.p7_drive;
      end else if (addr_hit(s_axi_araddr, `PPF_IDX_P8_CFG_HI)) begin
        st_next.rdata[`PPF_REG_W-1:0] = st_reg.cfg.p8_cfg_hi;
      end else if (addr_hit(s_axi_araddr, `PPF_IDX_P8_CFG_LO)) begin
        st_next.rdata[`PPF_REG_W-1:0] = st_reg.cfg.p8_cfg_lo;
      end else begin
        st_next.rresp = `PPF_RESP_SLVERR; // R5
      end
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // State register; reset leaves every pin an input, push-pull
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.cfg.p7_drive <= `PPF_RESET_VAL; // R7
      st_reg.cfg.p8_cfg_hi <= `PPF_RESET_VAL; // R7
      st_reg.cfg.p8_cfg_lo <= `PPF_RESET_VAL; // R7
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign cfg = st_reg.cfg;

  // ----------------------------------------------------------------
  // Pin function decode and pull-up gating
  // ----------------------------------------------------------------
  // Each pin's function follows its field directly from the register;
  // pull-ups on open-drain outputs stay usable as the external load.
  for (genvar i = 0; i < `PPF_PINS; i++) begin : g_pin
    if (i >= `PPF_HALF_PINS) begin : g_hi
      assign p8_field[i] =
        st_reg.cfg.p8_cfg_hi[`PPF_FIELD_W*(i-`PPF_HALF_PINS) +:
                             `PPF_FIELD_W]; // R2
    end else begin : g_lo
      assign p8_field[i] =
        st_reg.cfg.p8_cfg_lo[`PPF_FIELD_W*i +: `PPF_FIELD_W]; // R3
    end
    assign p8_fn.ext_mem_sel[i] = p8_field[i] == `PPF_FN_EXTMEM; // R1
    assign p8_fn.lcd_segment_output_sel[i] =
      p8_field[i] == `PPF_FN_LCD; // R1
    assign p8_fn.out_en_n[i] = p8_field[i] != `PPF_FN_OUTPUT; // R1
    assign p8_pullup_on[i] = p8_pullup_en[i] &&
      !((p8_field[i] == `PPF_FN_OUTPUT && !p8_open_drain[i]) ||
        p8_field[i] == `PPF_FN_EXTMEM ||
        p8_field[i] == `PPF_FN_LCD); // R6
    assign p7_pullup_on[i] = p7_pullup_en[i] &&
      !(p7_active_fn[i] && !st_reg.cfg.p7_drive[i]); // R6
  end
  assign p7_open_drain = st_reg.cfg.p7_drive; // R4

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_r1_output;
    (st_reg.cfg.p8_cfg_hi[7:6] == `PPF_FN_OUTPUT) |->
      !p8_fn.out_en_n[7] && !p8_fn.lcd_segment_output_sel[7];
  endproperty
  a_r1_output: assert property (p_r1_output) // R1
    else $error("pin 7 output code not decoded as output");

  property p_r1_lcd;
    (st_reg.cfg.p8_cfg_lo[3:2] == `PPF_FN_LCD) |->
      p8_fn.lcd_segment_output_sel[1] && !p8_fn.ext_mem_sel[1] &&
      p8_fn.out_en_n[1];
  endproperty
  a_r1_lcd: assert property (p_r1_lcd) // R1
    else $error("pin 1 LCD code not decoded");

  property p_r2_hi;
    (do_write && st_reg.w_lane0 &&
     wr_addr == ADDR_W'({`PPF_IDX_P8_CFG_HI, 2'b00})) |=>
      p8_field[7] == $past(st_reg.w_data[7:6]) &&
      p8_field[4] == $past(st_reg.w_data[1:0]);
  endproperty
  a_r2_hi: assert property (p_r2_hi) // R2
    else $error("high register write did not reach pins 7 and 4");

  property p_r3_lo;
    (do_write && st_reg.w_lane0 &&
     wr_addr == ADDR_W'({`PPF_IDX_P8_CFG_LO, 2'b00})) |=>
      p8_field[3] == $past(st_reg.w_data[7:6]) &&
      p8_field[0] == $past(st_reg.w_data[1:0]);
  endproperty
  a_r3_lo: assert property (p_r3_lo) // R3
    else $error("low register write did not reach pins 3 and 0");

  property p_r4_drive;
    (do_write && st_reg.w_lane0 &&
     wr_addr == ADDR_W'({`PPF_IDX_P7_DRIVE, 2'b00})) |=>
      p7_open_drain == $past(st_reg.w_data) && s_axi_bvalid;
  endproperty
  a_r4_drive: assert property (p_r4_drive) // R4
    else $error("drive mode write not seen on port 7");

  property p_r5_refuse;
    (do_write && !addr_known(wr_addr)) |=>
      s_axi_bresp == `PPF_RESP_SLVERR && $stable(st_reg.cfg);
  endproperty
  a_r5_refuse: assert property (p_r5_refuse) // R5
    else $error("unmapped write not refused or changed a register");

  // Port 8 and port 7 are checked apart, so neither can hide the other
  property p_r6_pullup;
    (p8_field[2] == `PPF_FN_EXTMEM) |-> !p8_pullup_on[2];
  endproperty
  a_r6_pullup: assert property (p_r6_pullup) // R6
    else $error("pull-up left on for an alternate function pin");

  property p_r6_p7_pullup;
    (p7_active_fn[1] && !st_reg.cfg.p7_drive[1]) |-> !p7_pullup_on[1];
  endproperty
  a_r6_p7_pullup: assert property (p_r6_p7_pullup) // R6
    else $error("port 7 pull-up left on for a push-pull driven pin");

  property p_r7_reset;
    @(posedge aclk) $rose(aresetn) |-> cfg == '0 && !s_axi_bvalid &&
      !s_axi_rvalid ##1 s_axi_awready && s_axi_wready && s_axi_arready;
  endproperty
  a_r7_reset: assert property (p_r7_reset) // R7
    else $error("configuration not cleared by reset");

endmodule : ppf_top

// File: test/ppf_pin_model.sv
// Pin-side model of port 8: works out each pad level.
// Assumes the decoded functions and pull-up outputs of ppf_top.
`timescale 1ns/1ps
module ppf_pin_model
  import ppf_pkg::*;
(
  input wire logic aclk,
  input wire ppf_pkg::ppf_p8_fn_s p8_fn,
  input wire logic [7:0] p8_pullup_on,
  input wire logic [7:0] p8_open_drain,
  input wire logic [7:0] out_val,
  output logic [7:0] pad
);
  logic [7:0] drift = 8'h00;
  // A floating pad wanders, so a stale level never passes for a match
  always @(posedge aclk) drift <= ~drift;
  // Low side pulls down; a released open-drain pad needs the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!p8_fn.out_en_n[i] && !(p8_open_drain[i] && out_val[i]))
        pad[i] = out_val[i];
      else if (p8_pullup_on[i]) pad[i] = 1'b1;
      else pad[i] = drift[i];
    end
  end
endmodule : ppf_pin_model

// File: test/ppf_top_bench.sv
// Self-checking bench for ppf_top with an AXI4-Lite master.
// Assumes the pin model beside it and byte addresses 4*index.
`timescale 1ns/1ps
module ppf_top_bench;
  import ppf_pkg::*;
  typedef struct {
    logic [7:0] a; logic [7:0] d; logic [1:0] r; logic [7:0] q;
  } ppf_row_s;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, p7_pu, p7_afn, p8_pu, p8_od, p8_out, pad;
  logic [7:0] p7_od, p7_pon, p8_pon;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  ppf_cfg_s cfg;
  ppf_p8_fn_s p8_fn;
  int bad_count = 0, num_checks = 0, cycles = 0;
  // Address, data, response, read-back
  ppf_row_s rows [6] = '{'{8'h80, 8'hE4, 2'h0, 8'hE4},
    '{8'h84, 8'h1B, 2'h0, 8'h1B}, '{8'h7C, 8'hA5, 2'h0, 8'hA5},
    '{8'h88, 8'hFF, 2'h2, 8'h00}, '{8'h81, 8'hFF, 2'h2, 8'h00},
    '{8'h1F, 8'hFF, 2'h2, 8'h00}};

  ppf_top u_ppf_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .p7_pullup_en(p7_pu),
    .p7_active_fn(p7_afn), .p8_pullup_en(p8_pu), .p8_open_drain(p8_od),
    .cfg(cfg), .p8_fn(p8_fn), .p7_open_drain(p7_od),
    .p7_pullup_on(p7_pon), .p8_pullup_on(p8_pon));
  ppf_pin_model u_ppf_pin_model (.aclk(aclk), .p8_fn(p8_fn),
    .p8_pullup_on(p8_pon), .p8_open_drain(p8_od), .out_val(p8_out),
    .pad(pad));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Cut a hang short well past the expected run of some 60 cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Ready and valid are sampled just after the launching edge; they hold
  // until the next edge, so this equals sampling at that edge
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] s);
    logic ap, wp, ha, hw, hb;
    awaddr <= a; wdata <= {24'h000000, d}; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    ap = 1'b1; wp = 1'b1; hb = 1'b0;
    while (ap || wp) begin
      #1; ha = ap && awready; hw = wp && wready;
      @(posedge aclk);
      if (ha) begin awvalid <= 1'b0; ap = 1'b0; end
      if (hw) begin wvalid <= 1'b0; wp = 1'b0; end
    end
    while (!hb) begin #1; hb = bvalid; resp = bresp; @(posedge aclk); end
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    logic h;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; h = 1'b0;
    while (!h) begin #1; h = arready; @(posedge aclk); end
    arvalid <= 1'b0; h = 1'b0;
    while (!h) begin
      #1; h = rvalid; rd = rdata; resp = rresp; @(posedge aclk);
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'h0; p7_pu = 8'hFF; p7_afn = 8'h0F;
    p8_pu = 8'hFF; p8_od = 8'h0F; p8_out = 8'h55;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    check(cfg, 32'h0);
    check(p8_fn, 32'h0000FF);
    check({awready, wready, arready, bvalid, rvalid}, 32'h1C);
    $display("test reset values done");
    @(posedge aclk);
    foreach (rows[i]) begin
      axi_write(rows[i].a, rows[i].d, 4'hF);
      check(resp, rows[i].r);
      axi_read(rows[i].a);
      check(rd, {24'h000000, rows[i].q});
      check(resp, rows[i].r);
    end
    $display("test register rows done");
    // Pins 7..0 now hold codes 11 10 01 00 00 01 10 11
    check(cfg, 32'hA5E41B);
    check(p8_fn, 32'h24427E);
    check(p7_od, 32'hA5);
    check(p8_pon, 32'h19);
    check(p7_pon, 32'hF5);
    check(pad & 8'h99, 32'h19);
    $display("test pin decode done");
    // Disabled byte lane must leave the register alone
    axi_write(8'h84, 8'h00, 4'h0);
    check(resp, 32'h0);
    check(cfg, 32'hA5E41B);
    $display("test strobe done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    check(cfg, 32'h0);
    check(p8_pon, 32'hFF);
    $display("test second reset done");
    test_done();
  end
endmodule : ppf_top_bench
